/* File: rtl/tmr_pkg.sv */
// Constants shared by the timer clear and clock select block
package tmr_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 8;
  localparam int SYNC_W = 5;
  localparam int MODE_W = 8;
  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_SYNC = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  localparam logic [7:0] OFF_CNT0 = 8'h20;
  localparam logic [7:0] OFF_STEP = 8'h04;
  // Control register fields
  localparam int CLR_MSB = 7;
  localparam int CLR_LSB = 5;
  localparam int EDGE_MSB = 4;
  localparam int EDGE_LSB = 3;
  localparam int PSC_MSB = 2;
  localparam int PSC_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] SYNC_RST = 5'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  // Mode register fields
  localparam int MODE_PH1 = 0;
  localparam int MODE_PH2 = 1;
  localparam int MODE_BUFC = 2;
  localparam int MODE_BUFD = 5;
  // Clear source codes
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LO = 2'h3;
  // Prescaler codes
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [2:0] PSC_X4 = 3'h4;
  localparam logic [2:0] PSC_X5 = 3'h5;
  localparam logic [2:0] PSC_X6 = 3'h6;
  localparam logic [2:0] PSC_X7 = 3'h7;
  // Divider taps: /4 /16 /64 /256 /1024
  localparam int DIV_W = 10;
  localparam int NTAP = 5;
  localparam int TAP_4 = 0;
  localparam int TAP_16 = 1;
  localparam int TAP_64 = 2;
  localparam int TAP_256 = 3;
  localparam int TAP_1024 = 4;
  localparam int NPIN = 4;
endpackage

/* File: rtl/tmr_prescaler.sv */
// Free-running divider giving rise/fall pulses of the divided clocks
`timescale 1ns/100ps
module tmr_prescaler #(
  parameter int DIV_W = tmr_pkg::DIV_W,
  parameter int NTAP  = tmr_pkg::NTAP
) (
  // Clock and reset
  input  wire logic            clock_in,
  input  wire logic            sys_rst_in,
  // Divided clock edges, one-cycle pulses
  output logic [NTAP-1:0]      rise_out,
  output logic [NTAP-1:0]      fall_out
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [NTAP-1:0]  lvl_q;
  logic [NTAP-1:0]  lvl_d;

  // Tap k is bit 2k+1: divide by 4, 16, 64, 256, 1024
  always_comb begin
    div_d = div_q + DIV_W'(1);
    for (int k = 0; k < NTAP; k++) begin
      lvl_d[k] = div_q[2*k+1];
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_q <= '0;
      lvl_q <= '0;
    end else begin
      div_q <= div_d;
      lvl_q <= lvl_d;
    end
  end

  assign rise_out = lvl_d & ~lvl_q;
  assign fall_out = ~lvl_d & lvl_q;
endmodule

/* File: rtl/tmr_pin_edge.sv */
// Edge detector for the external count clock pins
`timescale 1ns/100ps
module tmr_pin_edge #(
  parameter int NPIN = tmr_pkg::NPIN
) (
  // Clock and reset
  input  wire logic            clock_in,
  input  wire logic            sys_rst_in,
  // Pins, already synchronous to clock_in
  input  wire logic [NPIN-1:0] pin_in,
  // Edge pulses
  output logic [NPIN-1:0]      rise_out,
  output logic [NPIN-1:0]      fall_out
);
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_d;

  always_comb begin
    pin_d = pin_in;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign rise_out = pin_in & ~pin_q;
  assign fall_out = ~pin_in & pin_q;
endmodule

/* File: rtl/timer_clear_and_clock_select.sv */
// Five-channel counter clear source and clock source selection
// What this block does
// - Ch0,3,4: clear codes 000 and 100 disable clearing; all codes valid.
// - Code 001 clears on register A compare match or capture.
// - Code 010 clears on register B compare match or capture.
// - Codes 011/111 clear when another synchronised channel clears.
// - Ch0,3,4: code 101 clears on register C match or capture.
// - Ch0,3,4: code 110 clears on register D match or capture.
// - Only channels with their sync bit set join synchronous clearing.
// - Register C or D used as buffer raises no clear event.
// - Ch1,2: top clear bit reads 0, writes ignored.
// - Ch1,2: 00 off, 01 register A, 10 register B, 11 sync.
// - Ch0-2: prescale 000-011 count on clock /1, /4, /16, /64.
// - Ch0: prescale 100-111 count on external pins A-D.
// - Ch1: pins A, B, clock /256, channel 2 overflow or underflow.
// - Ch2: pins A, B, C, then clock /1024.
// - Ch1,2 in phase counting mode ignore prescale selection.
// - Edge field: 00 rising, 01 falling, 1X both; phase mode overrides.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module timer_clear_and_clock_select #(
  parameter int CNT_W = tmr_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    sys_rst_in,
  // Avalon-MM slave
  input  wire logic [7:0]              address_in,
  input  wire logic                    read_in,
  input  wire logic                    write_in,
  input  wire logic [3:0]              byteenable_in,
  input  wire logic [31:0]             writedata_in,
  output logic [31:0]                  readdata_out,
  output logic                         waitrequest_out,
  // External count clock pins A to D
  input  wire logic [3:0]              ext_clk_pin_in,
  // Per channel A,B,C,D compare match or capture pulses
  input  wire logic [4:0][3:0]         gr_event_in,
  // Phase counting steps for channels 1 and 2
  input  wire logic [1:0]              phase_up_in,
  input  wire logic [1:0]              phase_dn_in,
  // Count ticks for channels 3 and 4
  input  wire logic [1:0]              count_tick_in,
  // Counter values and clear pulses
  output logic [4:0][CNT_W-1:0]        chan_up_counter_out,
  output logic [4:0]                   clear_out
);
  localparam int NCH = tmr_pkg::NCH;

  logic [NCH-1:0][7:0]      ctrl_q;
  logic [NCH-1:0][7:0]      ctrl_d;
  logic [4:0]               sync_ctrl_reg_q;
  logic [4:0]               sync_ctrl_reg_d;
  logic [7:0]               mode_q;
  logic [7:0]               mode_d;
  logic                     wait_q;
  logic                     wait_d;
  logic [31:0]              rdata_q;
  logic [31:0]              rdata_d;
  logic [NCH-1:0][CNT_W-1:0] cnt_q;
  logic [NCH-1:0][CNT_W-1:0] cnt_d;
  logic [NCH-1:0]           clr_q;
  logic [NCH-1:0]           clr_d;

  logic [4:0]               div_rise;
  logic [4:0]               div_fall;
  logic [3:0]               pin_rise;
  logic [3:0]               pin_fall;
  logic                     wr_go;
  logic [NCH-1:0]           cnt_wr;
  logic [NCH-1:0]           own_clr;
  logic [NCH-1:0]           up;
  logic [NCH-1:0]           dn;
  logic                     sync_any;
  logic                     ovf2;

  tmr_prescaler u_presc (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .rise_out   (div_rise),
    .fall_out   (div_fall)
  );

  tmr_pin_edge u_pins (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (ext_clk_pin_in),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  // Count pulse from a source's edges under the edge field
  function automatic logic pick(input logic [1:0] edge_sel,
                                input logic r, input logic f);
    if (edge_sel[1]) begin
      pick = r | f;
    end else if (edge_sel[0]) begin
      pick = f;
    end else begin
      pick = r;
    end
  endfunction

  // Word index of a register offset
  function automatic logic [5:0] widx(input logic [7:0] off);
    widx = off[7:2];
  endfunction

  // Buffer flag of C or D for ch0, 3, 4; never set for ch1, 2
  function automatic logic buf_bit(input logic [7:0] m,
                                   input int base, input int ch);
    if (ch == 0) begin
      buf_bit = m[base];
    end else if (ch >= 3) begin
      buf_bit = m[base + ch - 2];
    end else begin
      buf_bit = 1'b0;
    end
  endfunction

  // Bus side: one wait state, write lands on the edge waitrequest is low
  assign wr_go = write_in & ~wait_q;

  always_comb begin
    ctrl_d = ctrl_q;
    sync_ctrl_reg_d = sync_ctrl_reg_q;
    mode_d = mode_q;
    rdata_d = rdata_q;
    cnt_wr = '0;
    wait_d = ~((read_in | write_in) & wait_q);
    if (read_in & wait_q) begin
      rdata_d = '0;
      for (int c = 0; c < NCH; c++) begin
        if (address_in[7:2] ==
            widx(tmr_pkg::OFF_CTRL0) + 6'(c)) begin
          rdata_d[7:0] = ctrl_q[c];
        end
        if (address_in[7:2] ==
            widx(tmr_pkg::OFF_CNT0) + 6'(c)) begin
          rdata_d[CNT_W-1:0] = cnt_q[c];
        end
      end
      if (address_in[7:2] == widx(tmr_pkg::OFF_SYNC)) begin
        rdata_d[4:0] = sync_ctrl_reg_q;
      end
      if (address_in[7:2] == widx(tmr_pkg::OFF_MODE)) begin
        rdata_d[7:0] = mode_q;
      end
    end
    if (wr_go & byteenable_in[0]) begin
      for (int c = 0; c < NCH; c++) begin
        if (address_in[7:2] ==
            widx(tmr_pkg::OFF_CTRL0) + 6'(c)) begin
          ctrl_d[c] = writedata_in[7:0];
          if (c == 1 || c == 2) begin
            ctrl_d[c][tmr_pkg::CLR_MSB] = 1'b0;
          end
        end
      end
      if (address_in[7:2] == widx(tmr_pkg::OFF_SYNC)) begin
        sync_ctrl_reg_d = writedata_in[4:0];
      end
      if (address_in[7:2] == widx(tmr_pkg::OFF_MODE)) begin
        mode_d = writedata_in[7:0];
      end
    end
    if (wr_go) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_wr[c] = address_in[7:2] ==
                    widx(tmr_pkg::OFF_CNT0) + 6'(c);
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= tmr_pkg::CTRL_RST;
      end
      sync_ctrl_reg_q <= tmr_pkg::SYNC_RST;
      mode_q <= tmr_pkg::MODE_RST;
      rdata_q <= '0;
      wait_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      sync_ctrl_reg_q <= sync_ctrl_reg_d;
      mode_q <= mode_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  // Clear sources and count sources
  always_comb begin
    logic [2:0] code;
    logic [2:0] psc;
    logic [1:0] eg;
    logic       ph;
    code = '0;
    psc = '0;
    eg = '0;
    ph = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      code = ctrl_q[c][tmr_pkg::CLR_MSB:tmr_pkg::CLR_LSB];
      unique case (code)
        tmr_pkg::CLR_A: own_clr[c] = gr_event_in[c][0];
        tmr_pkg::CLR_B: own_clr[c] = gr_event_in[c][1];
        // C/D codes are unreachable on ch1,2 since their top bit is 0
        tmr_pkg::CLR_C: own_clr[c] = gr_event_in[c][2] &
            ~buf_bit(mode_q, tmr_pkg::MODE_BUFC, c);
        tmr_pkg::CLR_D: own_clr[c] = gr_event_in[c][3] &
            ~buf_bit(mode_q, tmr_pkg::MODE_BUFD, c);
        default: own_clr[c] = 1'b0;
      endcase
    end
    sync_any = |(own_clr & sync_ctrl_reg_q);
    for (int c = 0; c < NCH; c++) begin
      clr_d[c] = own_clr[c] |
          ((ctrl_q[c][tmr_pkg::CLR_LSB+1:tmr_pkg::CLR_LSB] ==
            tmr_pkg::CLR_SYNC_LO) &
           sync_ctrl_reg_q[c] & sync_any);
    end
    up = '0;
    dn = '0;
    ovf2 = 1'b0;
    // Channel 2 first: its overflow can clock channel 1
    for (int i = 0; i < 3; i++) begin
      int c;
      c = 2 - i;
      psc = ctrl_q[c][tmr_pkg::PSC_MSB:tmr_pkg::PSC_LSB];
      eg = ctrl_q[c][tmr_pkg::EDGE_MSB:tmr_pkg::EDGE_LSB];
      unique case (psc)
        tmr_pkg::PSC_DIV1: up[c] = 1'b1;
        tmr_pkg::PSC_DIV4:
          up[c] = pick(eg, div_rise[tmr_pkg::TAP_4],
                       div_fall[tmr_pkg::TAP_4]);
        tmr_pkg::PSC_DIV16:
          up[c] = pick(eg, div_rise[tmr_pkg::TAP_16],
                       div_fall[tmr_pkg::TAP_16]);
        tmr_pkg::PSC_DIV64:
          up[c] = pick(eg, div_rise[tmr_pkg::TAP_64],
                       div_fall[tmr_pkg::TAP_64]);
        tmr_pkg::PSC_X4:
          up[c] = pick(eg, pin_rise[0], pin_fall[0]);
        tmr_pkg::PSC_X5:
          up[c] = pick(eg, pin_rise[1], pin_fall[1]);
        tmr_pkg::PSC_X6:
          if (c == 1) begin
            up[c] = pick(eg, div_rise[tmr_pkg::TAP_256],
                         div_fall[tmr_pkg::TAP_256]);
          end else begin
            up[c] = pick(eg, pin_rise[2], pin_fall[2]);
          end
        tmr_pkg::PSC_X7:
          if (c == 0) begin
            up[c] = pick(eg, pin_rise[3], pin_fall[3]);
          end else if (c == 1) begin
            up[c] = ovf2;
          end else begin
            up[c] = pick(eg, div_rise[tmr_pkg::TAP_1024],
                         div_fall[tmr_pkg::TAP_1024]);
          end
      endcase
      if (c > 0) begin
        ph = mode_q[tmr_pkg::MODE_PH1 + c - 1];
        if (ph) begin
          up[c] = phase_up_in[c-1];
          dn[c] = phase_dn_in[c-1] & ~phase_up_in[c-1];
        end
      end
      if (c == 2) begin
        ovf2 = (up[2] & (cnt_q[2] == {CNT_W{1'b1}})) |
               (dn[2] & (cnt_q[2] == '0));
      end
    end
    up[4:3] = count_tick_in;
    for (int c = 0; c < NCH; c++) begin
      if (cnt_wr[c]) begin
        cnt_d[c] = cnt_q[c];
        if (byteenable_in[0]) begin
          cnt_d[c][7:0] = writedata_in[7:0];
        end
        if (byteenable_in[1]) begin
          cnt_d[c][CNT_W-1:8] = writedata_in[CNT_W-1:8];
        end
      end else if (clr_d[c]) begin
        cnt_d[c] = '0;
      end else if (dn[c]) begin
        cnt_d[c] = cnt_q[c] - CNT_W'(1);
      end else if (up[c]) begin
        cnt_d[c] = cnt_q[c] + CNT_W'(1);
      end else begin
        cnt_d[c] = cnt_q[c];
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
      clr_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      clr_q <= clr_d;
    end
  end

  assign readdata_out = rdata_q;
  assign waitrequest_out = wait_q;
  assign chan_up_counter_out = cnt_q;
  assign clear_out = clr_q;
endmodule

/* File: verif/tmr_chk_assertions.sv */
// Port checker for the timer clear and clock select block
`timescale 1ns/100ps
module tmr_chk #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic                  clock_in,
  input wire logic                  sys_rst_in,
  // Register bus
  input wire logic [7:0]            address_in,
  input wire logic                  read_in,
  input wire logic                  write_in,
  input wire logic [3:0]            byteenable_in,
  input wire logic [31:0]           writedata_in,
  input wire logic [31:0]           readdata_out,
  input wire logic                  waitrequest_out,
  // Events, counters and clears
  input wire logic [4:0][3:0]       gr_event_in,
  input wire logic [4:0][CNT_W-1:0] chan_up_counter_out,
  input wire logic [4:0]            clear_out
);
  logic       bw;
  logic [2:0] c0_d;
  logic [2:0] c0_q;

  // Shadow of the channel 0 clear code, taken from accepted writes
  assign bw = write_in && !waitrequest_out;
  always_comb begin
    c0_d = c0_q;
    if (bw && address_in == 8'h00 && byteenable_in[0])
      c0_d = writedata_in[7:5];
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      c0_q <= 3'h0;
    else
      c0_q <= c0_d;
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  chk_wait_first: assert property ((read_in || write_in) && waitrequest_out
    |=> !waitrequest_out) else $error("Bus answer late");
  chk_wait_once: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("Wait request low too long");
  chk_clr_reg_a: assert property (
    !bw && gr_event_in[0][0] && c0_q == 3'h1 |=> clear_out[0])
    else $error("Register A event did not clear");
  chk_clr_reg_b: assert property (
    !bw && gr_event_in[0][1] && c0_q == 3'h2 |=> clear_out[0])
    else $error("Register B event did not clear");
  chk_clr_off: assert property (c0_q[1:0] == 2'h0 |=> !clear_out[0])
    else $error("Clear while clearing disabled");
  chk_clr_zero: assert property (
    clear_out[0] && !$past(bw) |-> chan_up_counter_out[0] == '0)
    else $error("Counter not zero on clear");
  chk_rd_resv: assert property (
    read_in && !waitrequest_out && address_in == 8'h04 |-> !readdata_out[7])
    else $error("Reserved clear bit reads one");
  chk_rd_unmap: assert property (read_in && !waitrequest_out
    && address_in[7:6] != 2'h0 |-> readdata_out == 32'h0)
    else $error("Unmapped read not zero");

  cover property (clear_out[0]);
  cover property (clear_out[1:0] == 2'h3);
  cover property (read_in && !waitrequest_out);
endmodule

bind timer_clear_and_clock_select tmr_chk #(.CNT_W(CNT_W)) u_chk (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .gr_event_in(gr_event_in),
  .chan_up_counter_out(chan_up_counter_out), .clear_out(clear_out));

/* File: verif/testbench.sv */
// Self-checking bench for the timer clear and clock select block
`timescale 1ns/100ps
module testbench;
  logic                          clock_in = 1'b0;
  logic                          sys_rst_in;
  logic [7:0]                    address_in;
  logic                          read_in;
  logic                          write_in;
  logic [3:0]                    byteenable_in;
  logic [31:0]                   writedata_in;
  logic [31:0]                   readdata_out;
  logic                          waitrequest_out;
  logic [3:0]                    ext_clk_pin_in;
  logic [4:0][3:0]               gr_event_in;
  logic [1:0]                    phase_up_in;
  logic [1:0]                    phase_dn_in;
  logic [1:0]                    count_tick_in;
  logic [4:0][tmr_pkg::CNT_W-1:0] chan_up_counter_out;
  logic [4:0]                    clear_out;
  logic [31:0]                   q;
  int                            mismatches;
  int                            num_checks;

  always #2 clock_in = ~clock_in;

  timer_clear_and_clock_select uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .ext_clk_pin_in(ext_clk_pin_in),
    .gr_event_in(gr_event_in), .phase_up_in(phase_up_in),
    .phase_dn_in(phase_dn_in), .count_tick_in(count_tick_in),
    .chan_up_counter_out(chan_up_counter_out), .clear_out(clear_out));

  task automatic chk(input logic [31:0] got, lo, hi);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  // Holds the request until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic lo_seen;
    int   n;
    n = 0;
    @(posedge clock_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= !w;
    do begin
      #1 lo_seen = (waitrequest_out === 1'b0);
      q = readdata_out;
      @(posedge clock_in);
      n++;
    end while (!lo_seen && n < 50);
    // A bus that never answers counts as a mismatch
    if (!lo_seen) chk(32'h1, 32'h0, 32'h0);
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  function automatic logic [31:0] cnt(input int ch);
    return 32'(chan_up_counter_out[ch]);
  endfunction

  function automatic logic ex(input int c, k);
    return (c == 1 && k == 0) || (c == 2 && k == 1) ||
           (c == 5 && k == 2) || (c == 6 && k == 3);
  endfunction

  // Counter held still by static pin A (ch3,4: an idle count tick) so only a clear can move it
  task automatic clr_try(input int ch, c, k, input logic e);
    acc(1, 8'(4 * ch), {24'h0, 3'(c), 5'h04});
    acc(1, 8'(32 + 4 * ch), 32'h5);
    @(posedge clock_in) gr_event_in[ch][k] <= 1'b1;
    @(posedge clock_in) gr_event_in[ch][k] <= 1'b0;
    #1 chk(32'(clear_out[ch]), 32'(e), 32'(e));
    chk(cnt(ch), e ? 0 : 5, e ? 0 : 5);
  endtask

  task automatic rate(input int ch, input logic [7:0] ctl, input int n,
                      input logic [31:0] lo, hi);
    acc(1, 8'(4 * ch), {24'h0, ctl});
    acc(1, 8'(32 + 4 * ch), 32'h0);
    repeat (n) @(posedge clock_in);
    #1 chk(cnt(ch), lo, hi);
  endtask

  task automatic pin_try(input int ch, input logic [7:0] ctl, input int k);
    acc(1, 8'(4 * ch), {24'h0, ctl});
    acc(1, 8'(32 + 4 * ch), 32'h0);
    repeat (5) begin
      @(posedge clock_in) ext_clk_pin_in[k] <= 1'b1;
      repeat (2) @(posedge clock_in);
      ext_clk_pin_in[k] <= 1'b0;
      repeat (2) @(posedge clock_in);
    end
    repeat (3) @(posedge clock_in);
    #1 chk(cnt(ch), 5, 5);
  endtask

  task automatic test_done;
    $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    test_done;
  end

  initial begin
    sys_rst_in = 1'b1;
    address_in = 8'h00;
    read_in = 1'b0;
    write_in = 1'b0;
    byteenable_in = 4'hF;
    writedata_in = 32'h0;
    ext_clk_pin_in = 4'h0;
    gr_event_in = '0;
    phase_up_in = 2'h0;
    phase_dn_in = 2'h0;
    count_tick_in = 2'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    foreach (q[i]) if (i < 4) begin
      acc(0, i == 3 ? 8'h40 : 8'(i * 12), 32'h0);
      chk(q, 0, 0);
    end
    acc(1, 8'h04, 32'hFF);
    acc(0, 8'h04, 32'h0);
    chk(q, 32'h7F, 32'h7F);
    $display("Test registers done");
    for (int c = 0; c < 8; c++)
      for (int k = 0; k < 4; k++)
        clr_try(0, c, k, ex(c, k));
    for (int c = 0; c < 4; c++)
      clr_try(1, c, c == 2 ? 1 : 0, c == 1 || c == 2);
    clr_try(3, 6, 3, 1);
    clr_try(4, 5, 2, 1);
    acc(1, 8'h18, 32'h04);
    clr_try(0, 5, 2, 0);
    acc(1, 8'h18, 32'h20);
    clr_try(0, 6, 3, 0);
    acc(1, 8'h18, 32'h0);
    acc(1, 8'h14, 32'h03);
    acc(1, 8'h04, 32'h64);
    acc(1, 8'h08, 32'h64);
    acc(1, 8'h24, 32'h7);
    acc(1, 8'h28, 32'h7);
    clr_try(0, 1, 0, 1);
    chk(32'(clear_out[2:1]), 1, 1);
    chk(cnt(1), 0, 0);
    chk(cnt(2), 7, 7);
    acc(1, 8'h14, 32'h0);
    $display("Test clear sources done");
    rate(0, 8'h00, 256, 255, 257);
    rate(0, 8'h01, 256, 63, 65);
    rate(0, 8'h02, 256, 15, 17);
    rate(2, 8'h03, 256, 3, 5);
    rate(0, 8'h11, 256, 127, 129);
    rate(0, 8'h09, 256, 63, 65);
    rate(1, 8'h06, 2048, 7, 9);
    rate(2, 8'h07, 4096, 3, 5);
    for (int k = 0; k < 4; k++)
      pin_try(0, 8'(4 + k), k);
    pin_try(1, 8'h04, 0);
    pin_try(1, 8'h05, 1);
    for (int k = 0; k < 3; k++)
      pin_try(2, 8'(4 + k), k);
    $display("Test clock sources done");
    acc(1, 8'h08, 32'h04);
    acc(1, 8'h28, 32'hFFFF);
    acc(1, 8'h04, 32'h07);
    acc(1, 8'h24, 32'h0);
    @(posedge clock_in) ext_clk_pin_in[0] <= 1'b1;
    repeat (4) @(posedge clock_in);
    ext_clk_pin_in[0] <= 1'b0;
    #1 chk(cnt(1), 1, 1);
    chk(cnt(2), 0, 0);
    // Prescale /1 with both edges would count every cycle if not overridden
    acc(1, 8'h18, 32'h01);
    acc(1, 8'h04, 32'h10);
    acc(1, 8'h24, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in) phase_up_in[0] <= (i < 3);
      phase_dn_in[0] <= (i == 3);
    end
    @(posedge clock_in) phase_dn_in[0] <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1 chk(cnt(1), 2, 2);
    // Channel 2 in phase mode with prescale /1 selected
    acc(1, 8'h18, 32'h02);
    acc(1, 8'h08, 32'h00);
    acc(1, 8'h28, 32'h0);
    @(posedge clock_in) phase_up_in[1] <= 1'b1;
    @(posedge clock_in) phase_up_in[1] <= 1'b0;
    #1 chk(cnt(2), 1, 1);
    acc(1, 8'h2C, 32'h0);
    repeat (3) begin
      @(posedge clock_in) count_tick_in[0] <= 1'b1;
      @(posedge clock_in) count_tick_in[0] <= 1'b0;
    end
    #1 chk(cnt(3), 3, 3);
    $display("Test overflow and phase done");
    test_done;
  end
endmodule
